/* File: verilog/dcc_consts.svh */
// dcc_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name in every design file that needs them
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// register offsets on the plain register port
`define DCC_ADDR_W            4
`define DCC_OFF_DAC_CTRL      4'h0
`define DCC_OFF_DAC_LEVEL     4'h1
`define DCC_OFF_CMP1_A        4'h2
`define DCC_OFF_CMP1_B        4'h3
`define DCC_OFF_CMP2_A        4'h4
`define DCC_OFF_CMP2_B        4'h5
`define DCC_OFF_CMP_SHARED    4'h6
`define DCC_OFF_CMP_FLAGS     4'h7

// ref_dac_control and ref_dac_level fields
`define DCC_DAC_ON_BIT        7
`define DCC_PIN_ONE_BIT       5
`define DCC_PIN_TWO_BIT       4
`define DCC_SRC_HI            3
`define DCC_SRC_LO            2
`define DCC_DAC_CTRL_WMASK    8'hBC
`define DCC_DAC_LEVEL_WMASK   8'h1F
`define DCC_LEVEL_W           5

// cmp_control_a fields
`define DCC_CMP_ON_BIT        7
`define DCC_CMP_RES_BIT       6
`define DCC_CMP_PIN_BIT       5
`define DCC_CMP_INV_BIT       4
`define DCC_CMP_SPEED_BIT     2
`define DCC_CMP_HYS_BIT       1
`define DCC_CMP_SYNC_BIT      0
`define DCC_CMP_A_WMASK       8'hB7

// cmp_control_b fields
`define DCC_CMP_RISE_BIT      7
`define DCC_CMP_FALL_BIT      6
`define DCC_CMP_PCH_HI        5
`define DCC_CMP_PCH_LO        4
`define DCC_CMP_NCH_HI        2
`define DCC_CMP_B_WMASK       8'hF7

// reset values
`define DCC_RST_ZERO          8'h00
`define DCC_CMP_A_RST         8'h04

// clocks per instruction cycle
`define DCC_INSTR_DIV         4

`endif

/* File: verilog/dcc_pkg.sv */
// dcc_pkg.sv: types shared by the reference dac and comparator control
// assumes: nothing; constants live in dcc_consts.svh
package dcc_pkg;

   // one-hot positive source of the ladder, all zero when reserved or off
   typedef enum logic [2:0] {
      DCC_SRC_NONE   = 3'h0,
      DCC_SRC_SUPPLY = 3'h1,
      DCC_SRC_EXTREF = 3'h2,
      DCC_SRC_FIXED  = 3'h4
   } dcc_src_t;

endpackage

/* File: verilog/dcc_cmp_if.sv */
// dcc_cmp_if.sv: control and result signals between top and one comparator channel
// assumes: one instance per comparator, all on clk_sys_i
`timescale 1ns/1ps
interface dcc_cmp_if;
   logic on;
   logic invert;
   logic sync_mode;
   logic rise_en;
   logic fall_en;
   logic result;
   logic ext_result;
   logic edge_evt;

   modport top  (output on, invert, sync_mode, rise_en, fall_en,
                 input  result, ext_result, edge_evt);
   modport chan (input  on, invert, sync_mode, rise_en, fall_en,
                 output result, ext_result, edge_evt);
endinterface

/* File: verilog/dcc_cmp_chan.sv */
// dcc_cmp_chan.sv: conditions one comparator's raw result
// assumes: raw result is asynchronous; timer clock level sampled on clk_sys_i
`timescale 1ns/1ps
`include "dcc_consts.svh"
module dcc_cmp_chan (
   // clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   // analog and timer side
   input  wire logic raw_i,
   input  wire logic instr_tick_i,
   input  wire logic timer_clk_i,
   // control and result
   dcc_cmp_if.chan   bus
);
   logic sync_a;
   logic sync_b;
   logic res_q;
   logic res_prev;
   logic tclk_prev;
   logic sync_q;
   logic cond;

   // two-stage synchroniser on the asynchronous raw result
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= raw_i;
         sync_b <= sync_a;
      end
   end

   // disabled comparator reads as low before polarity
   assign cond = (bus.on & sync_b) ^ bus.invert;

   // internal result updated once per instruction cycle
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         res_q    <= 1'b0;
         res_prev <= 1'b0;
      end else if (instr_tick_i) begin
         res_q    <= cond;
         res_prev <= res_q;
      end
   end

   // capture on falling edge of the prescaled timer clock
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tclk_prev <= 1'b0;
         sync_q    <= 1'b0;
      end else begin
         tclk_prev <= timer_clk_i;
         if (tclk_prev && !timer_clk_i)
            sync_q <= cond;
      end
   end

   // external path is unlatched unless synchronous mode
   assign bus.ext_result = bus.sync_mode ? sync_q : cond;
   assign bus.result     = res_q;
   // enabled edges of the latched result
   assign bus.edge_evt   = instr_tick_i &&
                           ((bus.rise_en && res_q && !res_prev) ||
                            (bus.fall_en && !res_q && res_prev));

   sync_chain_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sync_b == $past(raw_i, 2) || $past(rst_i, 2))
      else $error("synchroniser does not delay by two edges");
   latch_pol_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      instr_tick_i |=> res_q == (($past(bus.on) & $past(sync_b)) ^ $past(bus.invert)))
      else $error("latched result ignores polarity");
   hold_between_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !instr_tick_i |=> $stable(res_q))
      else $error("result changed outside an instruction cycle");
   sync_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !(tclk_prev && !timer_clk_i) |=> $stable(sync_q))
      else $error("sync capture outside timer falling edge");
   rise_evt_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      bus.edge_evt && res_q);
   sync_cap_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      bus.sync_mode && tclk_prev && !timer_clk_i);
endmodule

/* File: verilog/dcc_dac_ctl.sv */
// dcc_dac_ctl.sv: drives the ladder and dac pin controls from the dac registers
// assumes: register values come from flops in the top module
`timescale 1ns/1ps
`include "dcc_consts.svh"
module dcc_dac_ctl (
   // clock and reset
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_i,
   // register values
   input  wire logic [7:0]              ctrl_i,
   input  wire logic [7:0]              level_i,
   // pad levels for port reads
   input  wire logic [1:0]              pin_in_i,
   // analog controls
   output logic                         ladder_en_o,
   output logic [`DCC_LEVEL_W-1:0]      tap_o,
   output dcc_pkg::dcc_src_t            src_o,
   output logic [1:0]                   pin_connect_o,
   output logic [1:0]                   pin_read_o
);
   logic       on;
   logic [1:0] next_conn;
   dcc_pkg::dcc_src_t next_src;

   assign on = ctrl_i[`DCC_DAC_ON_BIT];
   // pins only connect while the ladder runs
   assign next_conn = on ? {ctrl_i[`DCC_PIN_TWO_BIT], ctrl_i[`DCC_PIN_ONE_BIT]}
                         : 2'h0;

   // positive source decode, reserved code selects nothing
   always_comb begin
      case (ctrl_i[`DCC_SRC_HI:`DCC_SRC_LO])
         2'h0:    next_src = dcc_pkg::DCC_SRC_SUPPLY;
         2'h1:    next_src = dcc_pkg::DCC_SRC_EXTREF;
         2'h2:    next_src = dcc_pkg::DCC_SRC_FIXED;
         default: next_src = dcc_pkg::DCC_SRC_NONE;
      endcase
      if (!on)
         next_src = dcc_pkg::DCC_SRC_NONE;
   end

   // registered analog controls
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ladder_en_o   <= 1'b0;
         tap_o         <= 5'h00;
         src_o         <= dcc_pkg::DCC_SRC_NONE;
         pin_connect_o <= 2'h0;
         pin_read_o    <= 2'h0;
      end else begin
         ladder_en_o   <= on;
         tap_o         <= level_i[`DCC_LEVEL_W-1:0];
         src_o         <= next_src;
         pin_connect_o <= next_conn;
         pin_read_o    <= pin_in_i & ~next_conn;
      end
   end

   ladder_follow_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ##1 ladder_en_o == $past(ctrl_i[`DCC_DAC_ON_BIT]))
      else $error("ladder enable does not follow dac on bit");
   off_open_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !ladder_en_o |-> pin_connect_o == 2'h0 && src_o == dcc_pkg::DCC_SRC_NONE)
      else $error("pins or source active while dac off");
   read_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (pin_connect_o & pin_read_o) == 2'h0)
      else $error("connected dac pin reads nonzero");
   pin_on_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      pin_connect_o == 2'h3);
endmodule

/* File: verilog/dcc_top.sv */
// dcc_top.sv: reference dac and dual comparator control block
// assumes: single clk_sys_i domain, plain register port, analog cores outside
//
// How it works
// - dac on bit enables the ladder
// - two pin enables connect dac level
// - connected pin drops digital driver, input detector
// - port read of dac pin returns zero
// - source field selects supply, pin, fixed
// - five-bit level code drives ladder tap
// - reset disables dac, opens pins, clears level
// - sleep wake leaves dac control untouched
// - unimplemented bits read zero, ignore writes
// - raw result high when plus above minus
// - two comparators, each with own registers
// - comparator enable bit powers the comparator
// - result in own register and shared mirror
// - pin drive needs enable, output direction, on
// - pin enable overrides latch, on ignored
// - internal result latched each instruction cycle
// - invert bit flips the comparison result
// - speed select resets to one, normal
// - hysteresis bit enables input hysteresis
// - each result offered as timer gate
// - sync mode captures on timer falling edge
// - enabled rise or fall edges set flag
`timescale 1ns/1ps
`include "dcc_consts.svh"
module dcc_top #(
   parameter int INSTR_DIV = `DCC_INSTR_DIV
) (
   // clock and reset
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_i,
   // register port
   input  wire logic [`DCC_ADDR_W-1:0]  reg_addr_i,
   input  wire logic [7:0]              reg_wdata_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   output logic [7:0]                   reg_rdata_o,
   // reference dac analog side
   output logic                         ref_ladder_en_o,
   output logic [`DCC_LEVEL_W-1:0]      ref_level_code_o,
   output dcc_pkg::dcc_src_t            ref_positive_source_o,
   output logic                         ref_out_pin_one_o,
   output logic                         ref_out_pin_two_o,
   output logic [1:0]                   ref_pin_digital_off_o,
   // dac pin port reads
   input  wire logic [1:0]              ref_pin_level_i,
   output logic [1:0]                   ref_pin_read_o,
   // comparator analog side
   input  wire logic [1:0]              cmp_raw_i,
   output logic [1:0]                   cmp_on_o,
   output logic [1:0]                   cmp_speed_select_o,
   output logic [1:0]                   cmp_hysteresis_on_o,
   output logic [3:0]                   cmp_pos_channel_o,
   output logic [5:0]                   cmp_neg_channel_o,
   // comparator pins
   input  wire logic [1:0]              pin_direction_i,
   input  wire logic [1:0]              port_latch_i,
   output logic [1:0]                   cmp_pin_out_o,
   output logic [1:0]                   cmp_pin_oe_o,
   output logic [1:0]                   cmp_pin_override_o,
   // gated timer side
   input  wire logic                    gated_timer_clk_i,
   output logic [1:0]                   cmp_gate_o,
   output logic [1:0]                   cmp_irq_flag_o
);
   // elaboration check on the divider
   if (INSTR_DIV < 1 || INSTR_DIV > 255) begin : g_bad_div
      $error("INSTR_DIV must lie in 1..255");
   end

   logic [7:0] ref_dac_control;
   logic [7:0] ref_dac_level;
   logic [7:0] cmp_control_a [2];
   logic [7:0] cmp_control_b [2];
   logic [1:0] cmp_result;
   logic [1:0] cmp_ext;
   logic [1:0] cmp_evt;
   logic [1:0] flag_clear;
   logic [7:0] next_rdata;
   logic [7:0] div_cnt;
   logic       instr_tick;
   logic       wr_dac_ctrl;
   logic       wr_dac_level;
   logic       wr_flags;
   logic [1:0] wr_cmp_a;
   logic [1:0] wr_cmp_b;

   dcc_cmp_if cmp_bus [2] ();

   // instruction cycle enable from the system clock
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt    <= 8'h00;
         instr_tick <= 1'b0;
      end else if (div_cnt == 8'(INSTR_DIV - 1)) begin
         div_cnt    <= 8'h00;
         instr_tick <= 1'b1;
      end else begin
         div_cnt    <= div_cnt + 8'h01;
         instr_tick <= 1'b0;
      end
   end

   // write decode
   assign wr_dac_ctrl  = reg_wr_i && reg_addr_i == `DCC_OFF_DAC_CTRL;
   assign wr_dac_level = reg_wr_i && reg_addr_i == `DCC_OFF_DAC_LEVEL;
   assign wr_flags     = reg_wr_i && reg_addr_i == `DCC_OFF_CMP_FLAGS;
   assign wr_cmp_a[0]  = reg_wr_i && reg_addr_i == `DCC_OFF_CMP1_A;
   assign wr_cmp_a[1]  = reg_wr_i && reg_addr_i == `DCC_OFF_CMP2_A;
   assign wr_cmp_b[0]  = reg_wr_i && reg_addr_i == `DCC_OFF_CMP1_B;
   assign wr_cmp_b[1]  = reg_wr_i && reg_addr_i == `DCC_OFF_CMP2_B;
   assign flag_clear   = wr_flags ? reg_wdata_i[1:0] : 2'h0;

   // dac registers; only device reset clears them, wake does not
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ref_dac_control <= `DCC_RST_ZERO;
         ref_dac_level   <= `DCC_RST_ZERO;
      end else begin
         if (wr_dac_ctrl)
            ref_dac_control <= reg_wdata_i & `DCC_DAC_CTRL_WMASK;
         if (wr_dac_level)
            ref_dac_level <= reg_wdata_i & `DCC_DAC_LEVEL_WMASK;
      end
   end

   // per comparator registers and conditioning channels
   for (genvar i = 0; i < 2; i++) begin : g_cmp
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
         if (rst_i) begin
            cmp_control_a[i] <= `DCC_CMP_A_RST;
            cmp_control_b[i] <= `DCC_RST_ZERO;
         end else begin
            if (wr_cmp_a[i])
               cmp_control_a[i] <= reg_wdata_i & `DCC_CMP_A_WMASK;
            if (wr_cmp_b[i])
               cmp_control_b[i] <= reg_wdata_i & `DCC_CMP_B_WMASK;
         end
      end

      assign cmp_bus[i].on        = cmp_control_a[i][`DCC_CMP_ON_BIT];
      assign cmp_bus[i].invert    = cmp_control_a[i][`DCC_CMP_INV_BIT];
      assign cmp_bus[i].sync_mode = cmp_control_a[i][`DCC_CMP_SYNC_BIT];
      assign cmp_bus[i].rise_en   = cmp_control_b[i][`DCC_CMP_RISE_BIT];
      assign cmp_bus[i].fall_en   = cmp_control_b[i][`DCC_CMP_FALL_BIT];
      assign cmp_result[i]        = cmp_bus[i].result;
      assign cmp_ext[i]           = cmp_bus[i].ext_result;
      assign cmp_evt[i]           = cmp_bus[i].edge_evt;

      dcc_cmp_chan u_chan (
         .clk_sys_i    (clk_sys_i),
         .rst_i        (rst_i),
         .raw_i        (cmp_raw_i[i]),
         .instr_tick_i (instr_tick),
         .timer_clk_i  (gated_timer_clk_i),
         .bus          (cmp_bus[i])
      );
   end

   // comparator analog controls
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cmp_on_o            <= 2'h0;
         cmp_speed_select_o  <= 2'h3;
         cmp_hysteresis_on_o <= 2'h0;
         cmp_pos_channel_o   <= 4'h0;
         cmp_neg_channel_o   <= 6'h00;
      end else begin
         for (int k = 0; k < 2; k++) begin
            cmp_on_o[k]            <= cmp_control_a[k][`DCC_CMP_ON_BIT];
            cmp_speed_select_o[k]  <= cmp_control_a[k][`DCC_CMP_SPEED_BIT];
            cmp_hysteresis_on_o[k] <= cmp_control_a[k][`DCC_CMP_HYS_BIT];
            cmp_pos_channel_o[2*k +: 2] <= cmp_control_b[k][`DCC_CMP_PCH_HI:`DCC_CMP_PCH_LO];
            cmp_neg_channel_o[3*k +: 3] <= cmp_control_b[k][`DCC_CMP_NCH_HI:0];
         end
      end
   end

   // comparator pin drive, override and timer gate
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cmp_pin_out_o      <= 2'h0;
         cmp_pin_oe_o       <= 2'h0;
         cmp_pin_override_o <= 2'h0;
         cmp_gate_o         <= 2'h0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            // pin enable replaces the port latch regardless of on
            cmp_pin_override_o[k] <= cmp_control_a[k][`DCC_CMP_PIN_BIT];
            cmp_pin_out_o[k] <= cmp_control_a[k][`DCC_CMP_PIN_BIT] ? cmp_ext[k]
                                                                     : port_latch_i[k];
            cmp_pin_oe_o[k]  <= cmp_control_a[k][`DCC_CMP_PIN_BIT] &&
                                !pin_direction_i[k] &&
                                cmp_control_a[k][`DCC_CMP_ON_BIT];
         end
         cmp_gate_o <= cmp_ext;
      end
   end

   // sticky edge flags, a new edge wins over a clear
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i)
         cmp_irq_flag_o <= 2'h0;
      else
         cmp_irq_flag_o <= (cmp_irq_flag_o & ~flag_clear) | cmp_evt;
   end

   // read mux; reserved and unmapped bits read zero
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr_i)
         `DCC_OFF_DAC_CTRL:   next_rdata = ref_dac_control;
         `DCC_OFF_DAC_LEVEL:  next_rdata = ref_dac_level;
         `DCC_OFF_CMP1_A:     next_rdata = cmp_control_a[0] |
                                           {1'b0, cmp_result[0], 6'h00};
         `DCC_OFF_CMP1_B:     next_rdata = cmp_control_b[0];
         `DCC_OFF_CMP2_A:     next_rdata = cmp_control_a[1] |
                                           {1'b0, cmp_result[1], 6'h00};
         `DCC_OFF_CMP2_B:     next_rdata = cmp_control_b[1];
         `DCC_OFF_CMP_SHARED: next_rdata = {6'h00, cmp_result};
         `DCC_OFF_CMP_FLAGS:  next_rdata = {6'h00, cmp_irq_flag_o};
         default:             next_rdata = 8'h00;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i)
         reg_rdata_o <= 8'h00;
      else
         reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
   end

   // reference dac output stage
   dcc_dac_ctl u_dac (
      .clk_sys_i     (clk_sys_i),
      .rst_i         (rst_i),
      .ctrl_i        (ref_dac_control),
      .level_i       (ref_dac_level),
      .pin_in_i      (ref_pin_level_i),
      .ladder_en_o   (ref_ladder_en_o),
      .tap_o         (ref_level_code_o),
      .src_o         (ref_positive_source_o),
      .pin_connect_o ({ref_out_pin_two_o, ref_out_pin_one_o}),
      .pin_read_o    (ref_pin_read_o)
   );

   // digital driver and detector off wherever the dac level sits
   assign ref_pin_digital_off_o = {ref_out_pin_two_o, ref_out_pin_one_o};

   pin_drive_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmp_pin_oe_o[0] |-> $past(cmp_control_a[0][`DCC_CMP_ON_BIT]) &&
                          !$past(pin_direction_i[0]) &&
                          $past(cmp_control_a[0][`DCC_CMP_PIN_BIT]))
      else $error("comparator pin driven without all three conditions");
   flag_keep_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmp_evt != 2'h0 |=> (cmp_irq_flag_o & $past(cmp_evt)) == $past(cmp_evt))
      else $error("edge event lost against flag clear");
   mask_bits_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ref_dac_control & ~`DCC_DAC_CTRL_WMASK) == 8'h00 &&
      (ref_dac_level & ~`DCC_DAC_LEVEL_WMASK) == 8'h00)
      else $error("unimplemented dac bit holds a one");
   read_slot_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == `DCC_OFF_CMP_SHARED ##1 !$past(instr_tick)
      |-> reg_rdata_o == {6'h00, cmp_result})
      else $error("shared result read does not mirror results");
   flag_set_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      wr_flags && cmp_evt != 2'h0);
endmodule

/* File: tb/dcc_analog_model.sv */
// dcc_analog_model.sv: behavioural comparator cores at the far side
// assumes: bench commands which input is higher per comparator
`timescale 1ns/1ps
module dcc_analog_model #(
   parameter int DLY = 3
) (
   // comparator controls and commanded inputs
   input  wire logic [1:0] on_i,
   input  wire logic [1:0] above_i,
   // raw comparator outputs
   output logic [1:0]      raw_o
);
   // high only while enabled and plus above minus
   assign #(DLY) raw_o = on_i & above_i;
endmodule

/* File: tb/dcc_top_tb_top.sv */
// dcc_top_tb_top.sv: self-checking bench for dac and comparator control
// assumes: default instruction divide, analog model on the raw inputs
`timescale 1ns/1ps
module dcc_top_tb_top;
   localparam int TW = 16;
   logic              clk_sys_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
   logic              gated_timer_clk_i = 0, ref_ladder_en_o;
   logic              ref_out_pin_one_o, ref_out_pin_two_o;
   logic [3:0]        reg_addr_i = 0, cmp_pos_channel_o;
   logic [7:0]        reg_wdata_i = 0, reg_rdata_o, rv;
   logic [4:0]        ref_level_code_o;
   logic [5:0]        cmp_neg_channel_o;
   dcc_pkg::dcc_src_t ref_positive_source_o;
   logic [1:0]        ref_pin_level_i = 2'h3, pin_direction_i = 0, port_latch_i = 0;
   logic [1:0]        above = 0, ref_pin_digital_off_o, ref_pin_read_o, cmp_raw_i;
   logic [1:0]        cmp_on_o, cmp_speed_select_o, cmp_hysteresis_on_o, cmp_pin_out_o;
   logic [1:0]        cmp_pin_oe_o, cmp_pin_override_o, cmp_gate_o, cmp_irq_flag_o;
   int                err_count = 0, n_tests = 0;
   dcc_top dcc_top_inst (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .ref_ladder_en_o, .ref_level_code_o, .ref_positive_source_o,
      .ref_out_pin_one_o, .ref_out_pin_two_o, .ref_pin_digital_off_o, .ref_pin_level_i,
      .ref_pin_read_o, .cmp_raw_i, .cmp_on_o, .cmp_speed_select_o, .cmp_hysteresis_on_o,
      .cmp_pos_channel_o, .cmp_neg_channel_o, .pin_direction_i, .port_latch_i,
      .cmp_pin_out_o, .cmp_pin_oe_o, .cmp_pin_override_o, .gated_timer_clk_i,
      .cmp_gate_o, .cmp_irq_flag_o);
   dcc_analog_model dcc_analog_model_inst (.on_i(cmp_on_o), .above_i(above),
      .raw_o(cmp_raw_i));
   // clocks: system and a slow timer source
   always #2.5 clk_sys_i = ~clk_sys_i;
   always #40 gated_timer_clk_i = ~gated_timer_clk_i;
   // compare and count
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask
   // one-cycle register read, data one cycle later
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 rv = reg_rdata_o;
   endtask
   task automatic settle;
      repeat (TW) @(negedge clk_sys_i);
   endtask
   task automatic t_reset;
      for (int i = 0; i < 8; i++) begin
         rd(4'(i));
         chk(rv, (i == 2 || i == 4) ? 8'h04 : 8'h00);
      end
      chk(8'(cmp_speed_select_o), 8'h03);
   endtask
   task automatic t_dac;
      dcc_pkg::dcc_src_t xs [4];
      xs = '{dcc_pkg::DCC_SRC_SUPPLY, dcc_pkg::DCC_SRC_EXTREF, dcc_pkg::DCC_SRC_FIXED,
             dcc_pkg::DCC_SRC_NONE};
      for (int s = 0; s < 4; s++) begin
         wr(4'h0, 8'hF3 | 8'(s << 2));
         rd(4'h0);
         chk(rv, 8'hB0 | 8'(s << 2));
         chk(8'(ref_positive_source_o), 8'(xs[s]));
      end
      chk(8'({ref_ladder_en_o, ref_out_pin_one_o, ref_out_pin_two_o}), 8'h07);
      chk(8'(ref_pin_digital_off_o), 8'h03);
      chk(8'(ref_pin_read_o), 8'h00);
      wr(4'h1, 8'hFF);
      rd(4'h1);
      chk(rv, 8'h1F);
      chk(8'(ref_level_code_o), 8'h1F);
      wr(4'h0, 8'h3C);
      rd(4'h0);
      chk(8'({ref_ladder_en_o, ref_out_pin_one_o, ref_out_pin_two_o}), 8'h00);
      chk(8'(ref_positive_source_o), 8'h00);
      chk(8'(ref_pin_read_o), 8'h03);
      wr(4'h0, 8'hB0);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(4'h0);
      chk(rv, 8'h00);
      rd(4'h1);
      chk(rv, 8'h00);
      chk(8'({ref_ladder_en_o, ref_out_pin_one_o, ref_level_code_o}), 8'h00);
   endtask
   task automatic t_cmp;
      @(posedge clk_sys_i);
      above <= 2'h1;
      port_latch_i <= 2'h3;
      wr(4'h2, 8'hA4);
      wr(4'h4, 8'h24);
      settle();
      rd(4'h2);
      chk(rv, 8'hE4);
      rd(4'h6);
      chk(rv, 8'h01);
      chk(8'(cmp_pin_oe_o), 8'h01);
      chk(8'(cmp_pin_override_o), 8'h03);
      chk(8'(cmp_pin_out_o), 8'h01);
      chk(8'({cmp_gate_o, cmp_on_o}), 8'h05);
      wr(4'h2, 8'hB2);
      settle();
      rd(4'h2);
      chk(rv, 8'hB2);
      chk(8'({cmp_hysteresis_on_o, cmp_speed_select_o}), 8'h06);
      @(posedge clk_sys_i);
      pin_direction_i <= 2'h1;
      rd(4'h6);
      chk(8'(cmp_pin_oe_o), 8'h00);
   endtask
   task automatic t_irq;
      wr(4'h3, 8'h80);
      wr(4'h7, 8'h03);
      rd(4'h7);
      chk(rv, 8'h00);
      @(posedge clk_sys_i);
      above <= 2'h0;
      settle();
      chk(8'(cmp_irq_flag_o), 8'h01);
      wr(4'h7, 8'h01);
      above <= 2'h1;
      settle();
      rd(4'h7);
      chk(rv, 8'h00);
   endtask
   // synchronous mode: gate and pin hold until the timer clock falls
   task automatic t_sync;
      @(posedge clk_sys_i);
      pin_direction_i <= 2'h0;
      wr(4'h3, 8'h35);
      wr(4'h2, 8'hA1);
      for (int i = 0; i < 40 && !gated_timer_clk_i; i++) begin
         @(posedge clk_sys_i);
      end
      for (int i = 0; i < 40 && gated_timer_clk_i; i++) begin
         @(posedge clk_sys_i);
      end
      chk(8'(gated_timer_clk_i), 8'h00);
      above <= 2'h0;
      repeat (8) @(negedge clk_sys_i);
      chk(8'({cmp_gate_o[0], cmp_pin_out_o[0], cmp_pin_oe_o[0]}), 8'h07);
      chk(8'({cmp_neg_channel_o[2:0], cmp_pos_channel_o[1:0]}), 8'h17);
      settle();
      chk(8'({cmp_gate_o[0], cmp_pin_out_o[0]}), 8'h00);
   endtask
   // verdict and end of run
   task automatic results;
      if (err_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_count++;
      results();
   end
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_reset();
      t_dac();
      t_cmp();
      t_irq();
      t_sync();
      results();
   end
endmodule
